// *** rtl/brf_regs.svh ***
// Purpose: Constants of the banked register file and status word
// Assumes: 32-bit words, five-bit mode field
// Notes:   Definitions only
`ifndef BRF_REGS_SVH
`define BRF_REGS_SVH
`define BRF_MODE_USR    5'h10
`define BRF_MODE_FIQ    5'h11
`define BRF_MODE_IRQ    5'h12
`define BRF_MODE_SVC    5'h13
`define BRF_MODE_ABT    5'h17
`define BRF_MODE_UND    5'h1B
`define BRF_MODE_SYS    5'h1F
`define BRF_RESET_MODE  `BRF_MODE_SVC
`define BRF_PSR_N       31
`define BRF_PSR_Z       30
`define BRF_PSR_C       29
`define BRF_PSR_V       28
`define BRF_PSR_Q       27
`define BRF_PSR_IT_LO   25
`define BRF_PSR_IT_HI   10
`define BRF_PSR_T       5
`define BRF_PSR_M       0
`define BRF_PC_OFS_FULL 32'h0000_0008
`define BRF_PC_OFS_CMP  32'h0000_0004
`define BRF_NREG        30
`define BRF_BASE_FIQ    5'h0F
`define BRF_BASE_IRQ    5'h16
`define BRF_BASE_SVC    5'h18
`define BRF_BASE_ABT    5'h1A
`define BRF_BASE_UND    5'h1C
`define BRF_SLOT_FIQ    3'h0
`define BRF_SLOT_IRQ    3'h1
`define BRF_SLOT_SVC    3'h2
`define BRF_SLOT_ABT    3'h3
`define BRF_SLOT_UND    3'h4
`define BRF_SLOT_NONE   3'h7
`define BRF_NSAVED      5
`endif

// *** rtl/brf_pkg.sv ***
// Purpose: Types of the banked register file
// Assumes: Constants in brf_regs.svh
// Notes:   Requests travel as packed structs
package brf_pkg;
    typedef logic [31:0] brf_word_type;
    typedef struct packed {
        logic [3:0] nzcv;
        logic       q;
        logic [7:0] it;
        logic       t;
        logic [4:0] mode;
    } brf_status_type;
    typedef struct packed {
        logic [3:0] idx;
        logic       user;
    } brf_rd_req_type;
    typedef struct packed {
        logic         en;
        logic [3:0]   idx;
        logic         user;
        brf_word_type data;
    } brf_wr_req_type;
    typedef struct packed {
        logic         en;
        logic         saved;
        logic         flags_byte;
        logic         ctrl_byte;
        brf_word_type data;
    } brf_sw_req_type;
    typedef struct packed {
        logic         en;
        logic [4:0]   mode;
        brf_word_type ret;
    } brf_exc_req_type;
    typedef struct packed {
        logic [3:0] code;
        logic       uncond;
        logic       branch;
    } brf_cond_req_type;
endpackage

// *** rtl/brf_core.sv ***
// Purpose: Mode-banked register file, program counter and status words
// Assumes: One core clock; pipeline supplies requests on that clock
// Notes:   Read data appears one cycle after the read index
`timescale 1ns/100ps
`include "brf_regs.svh"
// Contract
// - Sixteen addressable registers 0-15 shared by both states plus one status word.
// - Fast interrupt mode maps indices 8-14 onto seven private registers.
// - Supervisor, abort, interrupt, illegal-opcode modes bank indices 13 and 14.
// - User and system share user copies; other modes may request them explicitly.
// - Branch with link writes return address into index 14 of current mode.
// - Exception entry writes return value into index 14 of entered mode.
// - Program counter word-aligned in full state, halfword-aligned in compact state.
// - Reading index 15 gives instruction address plus 8 full, plus 4 compact.
// - Coprocessor transfer to 15 loads flags from bits 31:28, drops the rest.
// - Five saved words; only current privileged mode's saved word visible.
// - Exception entry saves pre-entry flags, state and mode into saved word.
// - Flags updated by arithmetic, status writes, coprocessor transfers; drive condition.
// - Full state executes conditionally except listed unconditional instruction classes.
// - Compact state: only branch self-conditional; others need a conditional block.
// - Saturation flag set by saturating ops, stays until status write clears it.
// - Saturation flag never used as an execution condition.
// - Upper three block bits hold base condition, zero when idle.
// - Lower five block bits hold count and then/else pattern, zero when idle.
// - Block-prefix instruction loads block state from condition and pattern.
// - After each block instruction lower five bits shift, count decrements.
// - Compact 16-bit forms reach 8-15 only through special high variants.
// - Mode field codes select bank: user, fiq, irq, svc, abort, undef, system.
// - Illegal mode written when privileged gives system; user mode writes ignored.
// - State bit set selects compact state, clear selects full state.
module brf_core #(
    parameter logic [31:0] RESET_PC = 32'h0000_0000
) (
    // Clock and reset
    input  wire  logic                     clk,
    input  wire  logic                     nrst,
    // Register read ports
    input  wire  brf_pkg::brf_rd_req_type  rd_a_req,
    input  wire  brf_pkg::brf_rd_req_type  rd_b_req,
    output logic [31:0]                    rd_a_data,
    output logic [31:0]                    rd_b_data,
    // Register write port and narrow-form qualifiers
    input  wire  brf_pkg::brf_wr_req_type  wr_req,
    input  wire  logic                     narrow_op,
    input  wire  logic                     high_variant,
    output logic                           access_err,
    // Link, coprocessor transfer and program counter step
    input  wire  logic                     link_en,
    input  wire  logic [31:0]              link_addr,
    input  wire  logic                     cp_xfer_en,
    input  wire  logic [31:0]              cp_xfer_data,
    input  wire  logic                     pc_step_en,
    input  wire  logic [31:0]              pc_step_addr,
    // Status updates
    input  wire  logic                     flag_en,
    input  wire  logic [3:0]               flag_nzcv,
    input  wire  logic                     sat_set,
    input  wire  brf_pkg::brf_sw_req_type  sw_req,
    input  wire  brf_pkg::brf_exc_req_type exc_req,
    // Conditional block control
    input  wire  logic                     it_load_en,
    input  wire  logic [7:0]               it_load_val,
    input  wire  logic                     it_advance,
    // Condition evaluation
    input  wire  brf_pkg::brf_cond_req_type cond_req,
    output logic                           cond_pass,
    // Visible state
    output logic [31:0]                    pc,
    output logic [31:0]                    current_status_word,
    output logic [31:0]                    saved_status_word,
    output logic                           compact_state
);

    // Register slots live here, next to the logic that indexes them
    typedef struct packed {
        brf_pkg::brf_word_type [`BRF_NREG-1:0]     gpr;
        brf_pkg::brf_word_type                     pc;
        brf_pkg::brf_status_type                   cur;
        brf_pkg::brf_status_type [`BRF_NSAVED-1:0] saved;
        brf_pkg::brf_word_type                     rd_a;
        brf_pkg::brf_word_type                     rd_b;
        logic                                      acc_err;
    } brf_state_type;

    brf_state_type r;
    brf_state_type next_r;

    function automatic logic is_legal(input logic [4:0] m);
        is_legal = (m == `BRF_MODE_USR) || (m == `BRF_MODE_FIQ) || (m == `BRF_MODE_IRQ) ||
                   (m == `BRF_MODE_SVC) || (m == `BRF_MODE_ABT) || (m == `BRF_MODE_UND) ||
                   (m == `BRF_MODE_SYS);
    endfunction

    function automatic logic [2:0] saved_slot(input logic [4:0] m);
        unique case (m)
            `BRF_MODE_FIQ: saved_slot = `BRF_SLOT_FIQ;
            `BRF_MODE_IRQ: saved_slot = `BRF_SLOT_IRQ;
            `BRF_MODE_SVC: saved_slot = `BRF_SLOT_SVC;
            `BRF_MODE_ABT: saved_slot = `BRF_SLOT_ABT;
            `BRF_MODE_UND: saved_slot = `BRF_SLOT_UND;
            default:       saved_slot = `BRF_SLOT_NONE;
        endcase
    endfunction

    // Only the five exception modes own a saved word
    function automatic logic has_saved(input logic [4:0] m);
        has_saved = (saved_slot(m) != `BRF_SLOT_NONE);
    endfunction

    // Physical slot of index 0-14 for a mode; user copies live at 0-14
    function automatic logic [4:0] phys(input logic [4:0] m, input logic [3:0] idx,
                                        input logic user);
        logic [4:0] base;
        base = 5'h00;
        phys = {1'b0, idx};
        if (!user) begin
            unique case (m)
                `BRF_MODE_FIQ: base = `BRF_BASE_FIQ;
                `BRF_MODE_IRQ: base = `BRF_BASE_IRQ;
                `BRF_MODE_SVC: base = `BRF_BASE_SVC;
                `BRF_MODE_ABT: base = `BRF_BASE_ABT;
                `BRF_MODE_UND: base = `BRF_BASE_UND;
                default:       base = 5'h00;
            endcase
            if (m == `BRF_MODE_FIQ && idx >= 4'h8) begin
                phys = base + {1'b0, idx} - 5'h08;
            end else if (base != 5'h00 && m != `BRF_MODE_FIQ && idx >= 4'hD) begin
                phys = base + {1'b0, idx} - 5'h0D;
            end
        end
    endfunction

    // Slot of the link register banked for a mode
    function automatic logic [4:0] lr_slot(input logic [4:0] m);
        lr_slot = phys(m, 4'hE, 1'b0);
    endfunction

    function automatic logic [31:0] align_pc(input logic [31:0] a, input logic t);
        align_pc = t ? {a[31:1], 1'b0} : {a[31:2], 2'b00};
    endfunction

    function automatic logic [31:0] read_reg(input brf_state_type s,
                                             input brf_pkg::brf_rd_req_type q);
        if (q.idx == 4'hF) begin
            read_reg = s.pc + (s.cur.t ? `BRF_PC_OFS_CMP : `BRF_PC_OFS_FULL);
        end else begin
            read_reg = s.gpr[phys(s.cur.mode, q.idx, q.user)];
        end
    endfunction

    function automatic logic [31:0] pack_psr(input brf_pkg::brf_status_type s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`BRF_PSR_N -: 4] = s.nzcv;
        w[`BRF_PSR_Q] = s.q;
        w[`BRF_PSR_IT_LO +: 2] = s.it[1:0];
        w[`BRF_PSR_IT_HI +: 6] = s.it[7:2];
        w[`BRF_PSR_T] = s.t;
        w[`BRF_PSR_M +: 5] = s.mode;
        pack_psr = w;
    endfunction

    function automatic brf_pkg::brf_status_type unpack_psr(input logic [31:0] w);
        unpack_psr.nzcv = w[`BRF_PSR_N -: 4];
        unpack_psr.q    = w[`BRF_PSR_Q];
        unpack_psr.it   = {w[`BRF_PSR_IT_HI +: 6], w[`BRF_PSR_IT_LO +: 2]};
        unpack_psr.t    = w[`BRF_PSR_T];
        unpack_psr.mode = w[`BRF_PSR_M +: 5];
    endfunction

    function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
        logic n;
        logic z;
        logic cy;
        logic v;
        logic base;
        {n, z, cy, v} = f;
        unique case (c[3:1])
            3'h0: base = z;
            3'h1: base = cy;
            3'h2: base = n;
            3'h3: base = v;
            3'h4: base = cy & ~z;
            3'h5: base = (n == v);
            3'h6: base = ~z & (n == v);
            3'h7: base = 1'b1;
        endcase
        cond_ok = (c[3:1] == 3'h7) ? 1'b1 : (base ^ c[0]);
    endfunction

    // Narrow forms see only indices 0-7 unless a special variant is used
    function automatic logic is_high(input logic [3:0] idx);
        is_high = idx[3];
    endfunction

    // Condition flags sit in the top nibble of any status-shaped word
    function automatic logic [3:0] flag_field(input logic [31:0] w);
        flag_field = w[`BRF_PSR_N -: 4];
    endfunction

    // One block instruction retired: shift the mask or close the block
    function automatic logic [7:0] block_step(input logic [7:0] it);
        block_step = it;
        if (it[2:0] == 3'h0) begin
            block_step = 8'h00;
        end else begin
            block_step[4:0] = {it[3:0], 1'b0};
        end
    endfunction

    // Effective condition of the active block and whether one is active
    logic       it_active;
    logic [3:0] it_cond;
    assign it_active = (r.cur.it[3:0] != 4'h0);
    assign it_cond   = r.cur.it[7:4];

    // Condition outcome is combinational so decode can use it in the same cycle
    always_comb begin
        if (cond_req.uncond) begin
            cond_pass = 1'b1;
        end else if (!r.cur.t) begin
            cond_pass = cond_ok(cond_req.code, r.cur.nzcv);
        end else if (it_active) begin
            cond_pass = cond_ok(it_cond, r.cur.nzcv);
        end else if (cond_req.branch) begin
            cond_pass = cond_ok(cond_req.code, r.cur.nzcv);
        end else begin
            cond_pass = 1'b1;
        end
    end

    always_comb begin
        logic        priv;
        logic        narrow_bad;
        logic [2:0]  slot;
        logic [4:0]  new_mode;
        logic [4:0]  dst;
        next_r     = r;
        priv       = (r.cur.mode != `BRF_MODE_USR);
        narrow_bad = 1'b0;
        slot       = `BRF_SLOT_NONE;
        new_mode   = r.cur.mode;
        dst        = 5'h00;

        // Narrow forms reach the high half only through their special variants
        if (narrow_op && !high_variant &&
            ((wr_req.en && is_high(wr_req.idx)) ||
             is_high(rd_a_req.idx) || is_high(rd_b_req.idx))) begin
            narrow_bad = 1'b1;
        end
        next_r.acc_err = narrow_bad;
        next_r.rd_a = (narrow_bad && rd_a_req.idx[3]) ? 32'h0000_0000 : read_reg(r, rd_a_req);
        next_r.rd_b = (narrow_bad && rd_b_req.idx[3]) ? 32'h0000_0000 : read_reg(r, rd_b_req);

        // Program counter: stepping, then branch writes override
        if (pc_step_en) begin
            next_r.pc = align_pc(pc_step_addr, r.cur.t);
        end

        // General write; index 15 branches
        if (wr_req.en && !(narrow_bad && is_high(wr_req.idx))) begin
            if (wr_req.idx == 4'hF) begin
                next_r.pc = align_pc(wr_req.data, r.cur.t);
            end else begin
                dst = phys(r.cur.mode, wr_req.idx, wr_req.user);
                next_r.gpr[dst] = wr_req.data;
            end
        end

        // Link write wins over a general write to the same register
        if (link_en) begin
            next_r.gpr[lr_slot(r.cur.mode)] = link_addr;
        end

        // Status word write; current execution-state bits are never touched here
        if (sw_req.en) begin
            if (sw_req.saved) begin
                slot = saved_slot(r.cur.mode);
                if (has_saved(r.cur.mode)) begin
                    next_r.saved[slot] = unpack_psr(sw_req.data);
                end
            end else begin
                if (sw_req.flags_byte) begin
                    next_r.cur.nzcv = flag_field(sw_req.data);
                    next_r.cur.q    = sw_req.data[`BRF_PSR_Q];
                end
                if (sw_req.ctrl_byte && priv) begin
                    new_mode = sw_req.data[`BRF_PSR_M +: 5];
                    next_r.cur.mode = is_legal(new_mode) ? new_mode
                                                         : `BRF_MODE_SYS;
                end
            end
        end

        // Flag sources in rising priority
        if (flag_en) begin
            next_r.cur.nzcv = flag_nzcv;
        end
        if (cp_xfer_en) begin
            next_r.cur.nzcv = flag_field(cp_xfer_data);
        end
        // Set beats a same-cycle clear
        if (sat_set) begin
            next_r.cur.q = 1'b1;
        end

        // Conditional block state
        if (it_advance && it_active) begin
            next_r.cur.it = block_step(r.cur.it);
        end
        if (it_load_en) begin
            next_r.cur.it = it_load_val;
        end

        // Exception entry overrides same-cycle updates to mode, block state, link slot and saved word
        if (exc_req.en) begin
            slot = saved_slot(exc_req.mode);
            if (has_saved(exc_req.mode)) begin
                next_r.saved[slot] = r.cur;
                next_r.gpr[lr_slot(exc_req.mode)] = exc_req.ret;
                next_r.cur.mode = exc_req.mode;
                next_r.cur.it   = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r          <= '0;
            r.pc       <= RESET_PC;
            r.cur.mode <= `BRF_RESET_MODE;
        end else begin
            r <= next_r;
        end
    end

    // Outputs
    always_comb begin
        logic [2:0] cs;
        cs = saved_slot(r.cur.mode);
        saved_status_word = (cs == `BRF_SLOT_NONE) ? 32'h0000_0000
                                                   : pack_psr(r.saved[cs]);
    end
    assign rd_a_data           = r.rd_a;
    assign rd_b_data           = r.rd_b;
    assign access_err          = r.acc_err;
    assign pc                  = r.pc;
    assign current_status_word = pack_psr(r.cur);
    assign compact_state       = r.cur.t;

endmodule // brf_core

// *** tb/brf_core_checker.sv ***
// Purpose: Port-level assertions for the banked register file
// Assumes: One clock, nrst asynchronous active low
// Notes:   Bound to brf_core after the module
`timescale 1ns/100ps
`include "brf_regs.svh"
module brf_core_checker (
    // Clock and reset
    input wire logic                      clk,
    input wire logic                      nrst,
    // Requests
    input wire brf_pkg::brf_rd_req_type   rd_a_req,
    input wire logic                      narrow_op,
    input wire logic                      high_variant,
    input wire logic                      cp_xfer_en,
    input wire logic [31:0]               cp_xfer_data,
    input wire logic                      sat_set,
    input wire brf_pkg::brf_sw_req_type   sw_req,
    input wire brf_pkg::brf_exc_req_type  exc_req,
    input wire logic                      it_load_en,
    input wire logic [7:0]                it_load_val,
    input wire logic                      it_advance,
    input wire brf_pkg::brf_cond_req_type cond_req,
    // Results
    input wire logic [31:0]               rd_a_data,
    input wire logic                      access_err,
    input wire logic                      cond_pass,
    input wire logic [31:0]               pc,
    input wire logic [31:0]               current_status_word,
    input wire logic [31:0]               saved_status_word,
    input wire logic                      compact_state
);
    logic [7:0] blk;
    assign blk = {current_status_word[15:10], current_status_word[26:25]};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_exc;
        exc_req.en && exc_req.mode inside {`BRF_MODE_FIQ, `BRF_MODE_IRQ,
            `BRF_MODE_SVC, `BRF_MODE_ABT, `BRF_MODE_UND};
    endsequence
    a_pc_align: assert property (!compact_state |-> pc[1:0] == 2'h0)
        else $error("pc not word aligned");
    a_pc_read: assert property (rd_a_req.idx == 4'hF && !narrow_op && !compact_state
        |=> rd_a_data == $past(pc) + 32'h8) else $error("pc read offset wrong");
    a_narrow_err: assert property (narrow_op && !high_variant && rd_a_req.idx[3]
        |=> access_err && rd_a_data == 32'h0) else $error("narrow high access not refused");
    a_cp_flags: assert property (cp_xfer_en && !exc_req.en
        |=> current_status_word[31:28] == $past(cp_xfer_data[31:28]))
        else $error("transfer flags wrong");
    a_sat_set: assert property (sat_set |=> current_status_word[27])
        else $error("saturation not set");
    a_sat_hold: assert property (current_status_word[27]
        && !(sw_req.en && !sw_req.saved && sw_req.flags_byte)
        |=> current_status_word[27]) else $error("saturation lost");
    a_exc_save: assert property (s_exc |=> saved_status_word == $past(current_status_word)
        && current_status_word[4:0] == $past(exc_req.mode)) else $error("entry save wrong");
    a_saved_hidden: assert property (current_status_word[4:0] inside
        {`BRF_MODE_USR, `BRF_MODE_SYS} |-> saved_status_word == 32'h0)
        else $error("saved word visible");
    a_it_load: assert property (it_load_en && !exc_req.en |=> blk == $past(it_load_val))
        else $error("block load wrong");
    a_it_shift: assert property (it_advance && !it_load_en && !exc_req.en
        && blk[2:0] != 3'h0 |=> blk == {$past(blk[7:5]), $past(blk[3:0]), 1'b0})
        else $error("block shift wrong");
    a_it_clear: assert property (it_advance && !it_load_en && blk[2:0] == 3'h0
        |=> blk == 8'h00) else $error("block not idle");
    a_uncond_pass: assert property (cond_req.uncond |-> cond_pass)
        else $error("unconditional op blocked");
endmodule // brf_core_checker
bind brf_core brf_core_checker brf_core_checker_i (.*);

// *** tb/brf_pipe_model.sv ***
// Purpose: Pipeline-side model issuing register reads and writes
// Assumes: Requests change at the falling edge, held one full cycle
// Notes:   Port b always reads index 15, so it tracks pc; narrow forms without the high variant read it as 0 and set access_err
`timescale 1ns/100ps
module brf_pipe_model (
    // Clock
    input  wire logic               clk,
    // Register port requests
    output brf_pkg::brf_rd_req_type rd_a_req,
    output brf_pkg::brf_rd_req_type rd_b_req,
    output brf_pkg::brf_wr_req_type wr_req,
    output logic                    narrow_op,
    output logic                    high_variant,
    // Read result
    input  wire logic [31:0]        rd_a_data
);
    initial begin
        rd_a_req = '0;
        rd_b_req = '{4'hF, 1'b0};
        wr_req = '0;
        narrow_op = 1'b0;
        high_variant = 1'b0;
    end
    task automatic wr(input logic [3:0] i, input logic u, input logic [31:0] d);
        @(negedge clk);
        wr_req <= '{1'b1, i, u, d};
        @(negedge clk);
        wr_req.en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] i, input logic u, output logic [31:0] d);
        @(negedge clk);
        rd_a_req <= '{i, u};
        @(negedge clk);
        d = rd_a_data;
    endtask
    task automatic form(input logic n, input logic h);
        @(negedge clk);
        narrow_op <= n;
        high_variant <= h;
    endtask
endmodule // brf_pipe_model

// *** tb/brf_core_bench.sv ***
// Purpose: Self-checking bench for the banked register file
// Assumes: 25 MHz clock, inputs change at the falling edge
// Notes:   T stays 0 here, so compact-state paths are not reached
`timescale 1ns/100ps
module brf_core_bench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    brf_pkg::brf_rd_req_type rd_a_req, rd_b_req;
    brf_pkg::brf_wr_req_type wr_req;
    brf_pkg::brf_sw_req_type sw_req = '0;
    brf_pkg::brf_exc_req_type exc_req = '0;
    brf_pkg::brf_cond_req_type cond_req = '0;
    logic narrow_op, high_variant, access_err, cond_pass, compact_state;
    logic link_en = 0, cp_xfer_en = 0, pc_step_en = 0, flag_en = 0, sat_set = 0;
    logic it_load_en = 0, it_advance = 0;
    logic [3:0] flag_nzcv = '0;
    logic [7:0] it_load_val = '0;
    logic [31:0] link_addr = '0, cp_xfer_data = '0, pc_step_addr = '0, v;
    logic [31:0] rd_a_data, rd_b_data, pc, current_status_word, saved_status_word;
    int err_count = 0;
    int tests_run = 0;
    always #20 clk = ~clk;
    brf_core brf_core_i (.*);
    brf_pipe_model brf_pipe_model_i (.*);
    function automatic logic [31:0] psr(input logic [3:0] f, input logic q, input logic [7:0] b);
        return {f, q, b[1:0], 9'h000, b[7:2], 5'h00, 5'h13};
    endfunction
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic rdc(input string n, input logic [3:0] i, input logic u, input logic [31:0] e);
        brf_pipe_model_i.rd(i, u, v);
        chk(n, v, e);
    endtask
    // Blocking at the falling edge keeps the pulse one clean cycle wide
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    task automatic sw(input logic s, input logic fb, input logic cb, input logic [31:0] d);
        @(negedge clk);
        sw_req = '{1'b1, s, fb, cb, d};
        @(negedge clk);
        sw_req.en = 1'b0;
    endtask
    task automatic cnd(input logic [5:0] r, input logic e);
        @(negedge clk);
        cond_req = r;
        #1;
        chk("cond", {31'h0, cond_pass}, {31'h0, e});
    endtask
    initial begin
        #100000;
        err_count++;
        summarize();
    end
    initial begin
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        chk("status", current_status_word, 32'h0000_0013);
        chk("pc", pc, 32'h0);
        brf_pipe_model_i.wr(4'h0, 1'b0, 32'h11);
        brf_pipe_model_i.wr(4'hD, 1'b0, 32'hA11);
        rdc("r0", 4'h0, 1'b0, 32'h11);
        rdc("r13 svc", 4'hD, 1'b0, 32'hA11);
        rdc("r13 usr", 4'hD, 1'b1, 32'h0);
        sw(1'b0, 1'b0, 1'b1, 32'h11);
        chk("mode", current_status_word, 32'h11);
        brf_pipe_model_i.wr(4'h8, 1'b0, 32'hF8);
        rdc("r8 fiq", 4'h8, 1'b0, 32'hF8);
        rdc("r8 usr", 4'h8, 1'b1, 32'h0);
        rdc("r0 fiq", 4'h0, 1'b0, 32'h11);
        sw(1'b0, 1'b0, 1'b1, 32'h15);
        chk("mode", current_status_word, 32'h1F);
        brf_pipe_model_i.wr(4'hD, 1'b0, 32'h5);
        sw(1'b0, 1'b0, 1'b1, 32'h10);
        rdc("r13 user", 4'hD, 1'b0, 32'h5);
        sw(1'b0, 1'b0, 1'b1, 32'h13);
        chk("mode", current_status_word, 32'h10);
        chk("saved", saved_status_word, 32'h0);
        @(negedge clk);
        exc_req = '{1'b1, 5'h13, 32'h200};
        @(negedge clk);
        exc_req.en = 1'b0;
        chk("saved", saved_status_word, 32'h10);
        chk("mode", current_status_word, 32'h13);
        rdc("r14 svc", 4'hE, 1'b0, 32'h200);
        rdc("r13 svc", 4'hD, 1'b0, 32'hA11);
        link_addr = 32'h300;
        pulse(link_en);
        rdc("r14 link", 4'hE, 1'b0, 32'h300);
        rdc("r14 usr", 4'hE, 1'b1, 32'h0);
        pc_step_addr = 32'h1003;
        pulse(pc_step_en);
        chk("pc", pc, 32'h1000);
        rdc("r15", 4'hF, 1'b0, 32'h1008);
        chk("r15 b", rd_b_data, 32'h1008);
        chk("state", {31'h0, compact_state}, 32'h0);
        brf_pipe_model_i.wr(4'hF, 1'b0, 32'h2002);
        chk("pc", pc, 32'h2000);
        cp_xfer_data = 32'hA123_4567;
        pulse(cp_xfer_en);
        chk("status", current_status_word, psr(4'hA, 1'b0, 8'h00));
        flag_nzcv = 4'h5;
        pulse(flag_en);
        chk("status", current_status_word, psr(4'h5, 1'b0, 8'h00));
        cnd(6'h00, 1'b1);
        cnd(6'h04, 1'b0);
        cnd(6'h06, 1'b1);
        cnd(6'h38, 1'b1);
        pulse(sat_set);
        chk("status", current_status_word, psr(4'h5, 1'b1, 8'h00));
        cnd(6'h1C, 1'b0);
        pulse(cp_xfer_en);
        chk("status", current_status_word, psr(4'hA, 1'b1, 8'h00));
        sw(1'b0, 1'b1, 1'b0, 32'h3000_0000);
        chk("status", current_status_word, psr(4'h3, 1'b0, 8'h00));
        it_load_val = 8'h4C;
        pulse(it_load_en);
        chk("block", current_status_word, psr(4'h3, 1'b0, 8'h4C));
        pulse(it_advance);
        chk("block", current_status_word, psr(4'h3, 1'b0, 8'h58));
        pulse(it_advance);
        chk("block", current_status_word, psr(4'h3, 1'b0, 8'h00));
        sw(1'b1, 1'b0, 1'b0, 32'h8000_0011);
        chk("saved", saved_status_word, 32'h8000_0011);
        brf_pipe_model_i.form(1'b1, 1'b0);
        rdc("narrow r9", 4'h9, 1'b0, 32'h0);
        chk("err", {31'h0, access_err}, 32'h1);
        brf_pipe_model_i.wr(4'h9, 1'b0, 32'h77);
        brf_pipe_model_i.form(1'b1, 1'b1);
        rdc("high r13", 4'hD, 1'b0, 32'hA11);
        rdc("high r9", 4'h9, 1'b0, 32'h0);
        chk("err", {31'h0, access_err}, 32'h0);
        summarize();
    end
endmodule // brf_core_bench
